/* hdl/spi_clock_gen.sv */
// Master serial clock generator: divider, source select and edge enables
module spi_clock_gen (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic timer_clock_i,
  input wire logic first_timer_output_i,
  input wire logic src_first_timer_output_i,
  input wire logic [1:0] div_code_i,
  output logic sck_level_o,
  spi_edge_if.gen edge_if
);
  import spi_wake_pkg::*;

  logic [3:0] cnt_q;
  logic tick;
  logic t0_q;
  logic tmr_q;
  logic base_tick;
  logic sck_q;

  // Each divided tick toggles the serial clock, so a full serial period is two ticks
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      t0_q <= 1'b0;
      tmr_q <= 1'b0;
    end else begin
      t0_q <= first_timer_output_i;
      tmr_q <= timer_clock_i;
    end
  end

  assign base_tick = src_first_timer_output_i ? (first_timer_output_i & ~t0_q) : (timer_clock_i & ~tmr_q);

  // Divide by 2, 4, 8, 16 of the chosen source
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 4'h0;
    end else if (!edge_if.run) begin
      cnt_q <= 4'h0;
    end else if (base_tick) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_comb begin
    unique case (div_code_i)
      2'b00: tick = base_tick;
      2'b01: tick = base_tick & cnt_q[0];
      2'b10: tick = base_tick & (&cnt_q[1:0]);
      2'b11: tick = base_tick & (&cnt_q[2:0]);
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_q <= 1'b0;
    end else if (!edge_if.run) begin
      sck_q <= 1'b0;
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end

  assign sck_level_o = sck_q;
  assign edge_if.sample_edge = edge_if.run & tick & ~sck_q;
  assign edge_if.drive_edge = edge_if.run & tick & sck_q;
endmodule : spi_clock_gen

/* hdl/spi_edge_if.sv */
// Interface: serial clock edge events from the clock generator to the shifter
interface spi_edge_if;
  logic sample_edge;
  logic drive_edge;
  logic run;
  modport gen (input run, output sample_edge, output drive_edge);
  modport use_side (output run, input sample_edge, input drive_edge);
endinterface : spi_edge_if

/* hdl/spi_wake_pkg.sv */
// Package: register map, field positions, reset values and timing for the serial port
package spi_wake_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_MATCH = 8'h03;
  localparam logic [7:0] ADDR_RECEIVE_BUFFER = 8'h04;
  localparam logic [7:0] ADDR_SHIFT = 8'h05;
  localparam logic [7:0] ADDR_RECOVERY = 8'h06;
  // Control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_DIV_LO = 1;
  localparam int CTL_OVERRUN = 1;
  localparam int CTL_DIV_HI = 2;
  localparam int CTL_DO_RELEASE = 2;
  localparam int CTL_COMPARE = 3;
  localparam int CTL_AVAIL = 4;
  localparam int CTL_PHASE = 5;
  localparam int CTL_CLKSRC = 6;
  localparam int CTL_MASTER = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Recovery register fields
  localparam int REC_SRC_LO = 2;
  localparam int REC_DELAY = 5;
  localparam int REC_LEVEL = 6;
  localparam int REC_WARM = 7;
  localparam logic [2:0] REC_SRC_RESET = 3'h0;
  localparam logic REC_DELAY_RESET = 1'b1;
  localparam logic REC_LEVEL_RESET = 1'b0;
  // Recovery delay: 5 ms at 200 MHz
  localparam int REF_CLK_MHZ = 200;
  localparam int RECOVERY_DELAY_MS = 5;
  localparam int RECOVERY_DELAY_CYCLES = RECOVERY_DELAY_MS * 1000 * REF_CLK_MHZ;
  // Role of the shifter
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_MASTER = 2'b01,
    SH_SLAVE = 2'b10,
    SH_IGNORE = 2'b11
  } shift_state_type;
endpackage : spi_wake_pkg

/* hdl/spi_wake_port.sv */
// Byte serial port with slave address compare and stop-mode recovery control
// How it works
// - Control bit 0 enables port; reset disabled.
// - Master: bits 2:1 pick clock divider.
// - Slave: bit 1 overrun, cleared by zero write.
// - Slave: bit 2 releases data-out pin.
// - Bit 3 enables compare with match register.
// - Bit 4 shows byte waiting; raises interrupt.
// - Bit 5 picks sample and drive edges.
// - Bit 6 picks timer-0 or divided clock.
// - Bit 7 picks master or slave role.
// - Slave transfer runs while select active.
// - Every full byte but the compare byte and bytes ignored after a mismatch sets available, interrupts.
// - Unread byte plus new byte: overwrite; overrun in slave only.
// - Master: shift register write starts transfer.
// - Compare: first byte silent; mismatch ignores rest.
// - Match raises wake, then normal slave transfer.
// - Buffer read clears available flag.
// - Compare match wakes regardless of source.
// - Three-bit field selects stop wake source.
// - Recovery bit 5 enables 5 ms delay.
// - Recovery bit 6 selects wake level.
// - Recovery bit 7 flags warm start.
// - Recovery fields write-only except bit 7.
module spi_wake_port #(
  parameter int DELAY_CYCLES = spi_wake_pkg::RECOVERY_DELAY_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic timer_clock_i,
  input wire logic first_timer_output_i,
  input wire logic serial_data_input_i,
  input wire logic slave_select_n_i,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output logic port2_bit7_pin_o,
  output logic port2_bit7_pin_oe_o,
  input wire logic port2_bit7_pin_i,
  input wire logic port3_bit1_input_i,
  input wire logic port3_bit2_input_i,
  input wire logic port3_bit3_input_i,
  input wire logic [7:0] port2_i,
  input wire logic stop_mode_i,
  input wire logic watchdog_reset_i,
  output logic receive_interrupt_line_o,
  output logic stop_wake_o,
  output logic recovery_delay_busy_o
);
  import spi_wake_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic enable_q, master_q, clksrc_q, phase_q, compare_q, do_release_q;
  logic [1:0] div_q;
  logic receive_available_flag_q, receive_overrun_flag_q;
  logic [7:0] match_value_register_q, receive_buffer_q, shift_q;
  logic [2:0] rec_src_q;
  logic rec_delay_q, rec_level_q, warm_q;
  logic [7:0] rdata_q;
  shift_state_type state_q;
  logic [2:0] bitcnt_q;
  logic first_byte_q;
  logic out_bit_q;
  logic sk_q, ss_q;
  logic byte_done, match_event, slave_mode;
  logic samp, drv, sk_rise, sk_fall;
  logic wr_ctl, wr_shift, rd_buf;
  logic [7:0] shift_next;
  logic src_level, src_prev_q, src_event;
  logic [31:0] delay_q;
  logic sck_level;

  spi_edge_if edge_if ();

  spi_clock_gen u_clk (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .timer_clock_i(timer_clock_i),
    .first_timer_output_i(first_timer_output_i),
    .src_first_timer_output_i(clksrc_q),
    .div_code_i(div_q),
    .sck_level_o(sck_level),
    .edge_if(edge_if.gen)
  );

  assign wr_ctl = wr_i && (addr_i == ADDR_CONTROL);
  assign wr_shift = wr_i && (addr_i == ADDR_SHIFT);
  assign rd_buf = rd_i && (addr_i == ADDR_RECEIVE_BUFFER);
  assign slave_mode = enable_q && !master_q;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_q <= CONTROL_RESET[CTL_ENABLE];
      div_q <= CONTROL_RESET[CTL_DIV_HI:CTL_DIV_LO];
      do_release_q <= CONTROL_RESET[CTL_DO_RELEASE];
      compare_q <= CONTROL_RESET[CTL_COMPARE];
      phase_q <= CONTROL_RESET[CTL_PHASE];
      clksrc_q <= CONTROL_RESET[CTL_CLKSRC];
      master_q <= CONTROL_RESET[CTL_MASTER];
    end else if (wr_ctl) begin
      enable_q <= wdata_i[CTL_ENABLE];
      div_q <= wdata_i[CTL_DIV_HI:CTL_DIV_LO];
      do_release_q <= wdata_i[CTL_DO_RELEASE];
      compare_q <= wdata_i[CTL_COMPARE];
      phase_q <= wdata_i[CTL_PHASE];
      clksrc_q <= wdata_i[CTL_CLKSRC];
      master_q <= wdata_i[CTL_MASTER];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_value_register_q <= 8'h00;
    end else if (wr_i && addr_i == ADDR_MATCH) begin
      match_value_register_q <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Serial clock edges
  // ----------------------------------------------------------------
  // Pins are synchronous; one register gives the edge history
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sk_q <= 1'b0;
      ss_q <= 1'b1;
    end else begin
      sk_q <= serial_clock_pin_i;
      ss_q <= slave_select_n_i;
    end
  end

  assign sk_rise = serial_clock_pin_i & ~sk_q;
  assign sk_fall = ~serial_clock_pin_i & sk_q;

  // Master clock idles at the drive level so the first edge samples
  always_comb begin
    if (master_q) begin
      samp = edge_if.sample_edge;
      drv = edge_if.drive_edge;
    end else begin
      samp = phase_q ? sk_fall : sk_rise;
      drv = phase_q ? sk_rise : sk_fall;
    end
  end

  assign edge_if.run = (state_q == SH_MASTER);
  assign serial_clock_pin_o = phase_q ? ~sck_level : sck_level;
  assign serial_clock_pin_oe_o = enable_q && master_q;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  assign shift_next = {shift_q[6:0], serial_data_input_i};
  assign byte_done = samp && (bitcnt_q == 3'h7) &&
                     (state_q == SH_MASTER || state_q == SH_SLAVE);
  assign match_event = byte_done && state_q == SH_SLAVE && first_byte_q &&
                       (shift_next == match_value_register_q);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= SH_IDLE;
      bitcnt_q <= 3'h0;
      shift_q <= 8'h00;
      first_byte_q <= 1'b0;
      out_bit_q <= 1'b0;
    end else if (!enable_q) begin
      state_q <= SH_IDLE;
      bitcnt_q <= 3'h0;
    end else begin
      unique case (state_q)
        SH_IDLE: begin
          bitcnt_q <= 3'h0;
          if (master_q && wr_shift) begin
            shift_q <= wdata_i;
            out_bit_q <= wdata_i[7];
            state_q <= SH_MASTER;
          end else if (!master_q && !slave_select_n_i) begin
            first_byte_q <= compare_q;
            out_bit_q <= shift_q[7];
            state_q <= SH_SLAVE;
          end else if (!master_q && wr_shift) begin
            shift_q <= wdata_i;
          end
        end
        SH_MASTER, SH_SLAVE: begin
          if (state_q == SH_SLAVE && slave_select_n_i) begin
            state_q <= SH_IDLE;
          end else begin
            if (samp) begin
              shift_q <= shift_next;
              bitcnt_q <= bitcnt_q + 3'h1;
            end
            if (drv) begin
              out_bit_q <= shift_q[7];
            end
            if (byte_done) begin
              if (state_q == SH_MASTER) begin
                state_q <= SH_IDLE;
              end else if (first_byte_q) begin
                first_byte_q <= 1'b0;
                if (shift_next != match_value_register_q) begin
                  state_q <= SH_IGNORE;
                end
              end
            end
          end
        end
        SH_IGNORE: begin
          if (slave_select_n_i) begin
            state_q <= SH_IDLE;
          end
        end
      endcase
    end
  end

  // Data-out drives only during an active, non-compare exchange
  assign port2_bit7_pin_o = out_bit_q;
  assign port2_bit7_pin_oe_o = (state_q == SH_MASTER) ||
      (state_q == SH_SLAVE && !first_byte_q && !do_release_q);

  // ----------------------------------------------------------------
  // Receive buffer and flags
  // ----------------------------------------------------------------
  // The compare byte never reaches the buffer
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_buffer_q <= 8'h00;
    end else if (byte_done && !first_byte_q) begin
      receive_buffer_q <= shift_next;
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_available_flag_q <= 1'b0;
    end else if (byte_done && !first_byte_q) begin
      receive_available_flag_q <= 1'b1;
    end else if (rd_buf) begin
      receive_available_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_overrun_flag_q <= 1'b0;
    end else if (byte_done && !first_byte_q && state_q == SH_SLAVE &&
                 receive_available_flag_q && !rd_buf) begin
      receive_overrun_flag_q <= 1'b1;
    end else if (wr_ctl && !wdata_i[CTL_OVERRUN]) begin
      receive_overrun_flag_q <= 1'b0;
    end
  end

  assign receive_interrupt_line_o = enable_q && receive_available_flag_q;

  // ----------------------------------------------------------------
  // Stop-mode recovery
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rec_src_q <= REC_SRC_RESET;
      rec_delay_q <= REC_DELAY_RESET;
      rec_level_q <= REC_LEVEL_RESET;
    end else if (wr_i && addr_i == ADDR_RECOVERY) begin
      rec_src_q <= wdata_i[REC_SRC_LO+2:REC_SRC_LO];
      rec_delay_q <= wdata_i[REC_DELAY];
      rec_level_q <= wdata_i[REC_LEVEL];
    end
  end

  // Set on stop entry; cleared by power-on or watchdog reset
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      warm_q <= 1'b0;
    end else if (watchdog_reset_i) begin
      warm_q <= 1'b0;
    end else if (stop_mode_i) begin
      warm_q <= 1'b1;
    end
  end

  always_comb begin
    unique case (rec_src_q)
      3'b010: src_level = port3_bit1_input_i;
      3'b011: src_level = port3_bit2_input_i;
      3'b100: src_level = port3_bit3_input_i;
      3'b101: src_level = port2_bit7_pin_i;
      3'b110: src_level = ~(|port2_i[3:0]);
      3'b111: src_level = ~(|port2_i);
      default: src_level = ~rec_level_q;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // A wake needs a transition into the chosen level; codes 000/001 never wake
  assign src_event = rec_src_q[2:1] != 2'b00 && src_level == rec_level_q &&
                     src_prev_q != rec_level_q;

  // Compare wakes in any source setting
  assign stop_wake_o = match_event || (stop_mode_i && src_event);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      delay_q <= 32'h0;
    end else if (stop_wake_o && stop_mode_i && rec_delay_q) begin
      delay_q <= DELAY_CYCLES[31:0];
    end else if (delay_q != 32'h0) begin
      delay_q <= delay_q - 32'h1;
    end
  end

  assign recovery_delay_busy_o = (delay_q != 32'h0);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_CONTROL: rdata_q <= {master_q, clksrc_q, phase_q, receive_available_flag_q,
                                  compare_q, do_release_q | (master_q & div_q[1]),
                                  master_q ? div_q[0] : receive_overrun_flag_q,
                                  enable_q};
        ADDR_MATCH: rdata_q <= match_value_register_q;
        ADDR_RECEIVE_BUFFER: rdata_q <= receive_buffer_q;
        ADDR_SHIFT: rdata_q <= shift_q;
        ADDR_RECOVERY: rdata_q <= {warm_q, 7'h00};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;
endmodule : spi_wake_port

/* verification/spi_ext_master.sv */
// Partner model: external serial master that frames and clocks slave transfers
module spi_ext_master (
  input wire logic ref_clk_i,
  input wire logic phase_i,
  input wire logic dout_oe_i,
  input wire logic dout_i,
  output logic sel_n_o,
  output logic sck_o,
  output logic di_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;
  // Byte seen on data-out during the last transfer, read on the slave's sample edge
  logic [7:0] rx_q;
  initial begin
    rx_q = 8'h00;
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    di_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick
  // Clock rests at its idle level before select moves, so no stray edge lands in a frame
  task automatic frame(input logic on);
    sck_o <= phase_i;
    tick(HALF);
    sel_n_o <= !on;
    tick(HALF);
  endtask : frame
  task automatic set_di(input logic v);
    di_o <= v;
  endtask : set_di
  // Most significant bit first; reports whether data-out was driven during the byte
  task automatic xfer(input logic [7:0] tx, output logic drove);
    drove = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      di_o <= tx[i];
      tick(HALF);
      sck_o <= !phase_i;
      // Look before the slave acts on this edge: a match may switch data-out on right after
      #1;
      drove = drove | dout_oe_i;
      rx_q = {rx_q[6:0], dout_i};
      tick(2);
      di_o <= !tx[i];
      tick(2);
      sck_o <= phase_i;
    end
  endtask : xfer
endmodule : spi_ext_master

/* verification/spi_wake_port_sva.sv */
// Checker: port-level properties of the compare-wake serial port
module spi_wake_port_sva #(
  parameter int DELAY_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic port2_bit7_pin_oe_o,
  input wire logic stop_mode_i,
  input wire logic receive_interrupt_line_o,
  input wire logic stop_wake_o,
  input wire logic recovery_delay_busy_o
);
  import spi_wake_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ----
  // Shadows of software-written bits
  // ----
  logic [7:0] ctl_q;
  logic dly_q;
  int busy_q;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= CONTROL_RESET;
      dly_q <= REC_DELAY_RESET;
    end else if (wr_i && addr_i == ADDR_CONTROL) begin
      ctl_q <= wdata_i;
    end else if (wr_i && addr_i == ADDR_RECOVERY) begin
      dly_q <= wdata_i[REC_DELAY];
    end
  end
  // Length of the current busy stretch, so the delay figure can be bounded
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) busy_q <= 0;
    else busy_q <= recovery_delay_busy_o ? busy_q + 1 : 0;
  end
  sequence s_rd(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence s_stop_wake;
    stop_wake_o && stop_mode_i && dly_q;
  endsequence
  // ----
  // Properties
  // ----
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_REC_RD: assert property (s_rd(ADDR_RECOVERY) |=> rdata_o[6:0] == 7'h00)
    else $error("recovery register read shows write-only bits");
  AST_CTL_RD: assert property (s_rd(ADDR_CONTROL) |=> rdata_o[7:5] == $past(ctl_q[7:5])
    && rdata_o[3] == $past(ctl_q[3]) && rdata_o[0] == $past(ctl_q[0]))
    else $error("control readback differs from written bits");
  AST_SCK_OE: assert property (serial_clock_pin_oe_o == (ctl_q[CTL_ENABLE] && ctl_q[CTL_MASTER]))
    else $error("clock pin drive does not follow master enable");
  AST_OFF_QUIET: assert property (!ctl_q[CTL_ENABLE] && !$past(ctl_q[CTL_ENABLE])
    |-> !port2_bit7_pin_oe_o && !receive_interrupt_line_o)
    else $error("disabled port drives data-out or interrupt");
  AST_RELEASE: assert property (ctl_q[CTL_ENABLE] && !ctl_q[CTL_MASTER]
    && ctl_q[CTL_DO_RELEASE] && $stable(ctl_q) |-> !port2_bit7_pin_oe_o)
    else $error("released data-out pin still driven");
  AST_WAKE_PULSE: assert property (stop_wake_o |=> !stop_wake_o)
    else $error("wake longer than one cycle");
  AST_WAKE_CAUSE: assert property (stop_wake_o |-> stop_mode_i
    || (ctl_q[CTL_COMPARE] && ctl_q[CTL_ENABLE] && !ctl_q[CTL_MASTER]))
    else $error("wake without stop or slave compare");
  AST_DLY_START: assert property (s_stop_wake |-> ##[0:2] recovery_delay_busy_o)
    else $error("recovery delay did not start");
  AST_DLY_LEN: assert property ($fell(recovery_delay_busy_o) |->
    busy_q >= DELAY_CYCLES - 2 && busy_q <= DELAY_CYCLES + 2)
    else $error("recovery delay length wrong");
endmodule : spi_wake_port_sva
bind spi_wake_port spi_wake_port_sva #(.DELAY_CYCLES(DELAY_CYCLES)) u_sva (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .port2_bit7_pin_oe_o(port2_bit7_pin_oe_o), .stop_mode_i(stop_mode_i),
  .receive_interrupt_line_o(receive_interrupt_line_o), .stop_wake_o(stop_wake_o),
  .recovery_delay_busy_o(recovery_delay_busy_o));

/* verification/spi_with_compare_wakeup_tb_top.sv */
// Testbench: register-level scenarios for the compare-wake serial port
module spi_with_compare_wakeup_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_wake_pkg::*;
  localparam int DLY = 20;
  logic clk, nrst, wr, rd, timer_clock, stop, wdr, t0, ph, drove;
  // Wake sources: 0..2 port 3 bits, 3 data-out pad, 11:4 port 2
  logic [11:0] src;
  logic ssn, msck, di, sck_o, sck_oe, sck_w, do_o, do_oe, do_w, irq, wake, busy, sck_l;
  logic [7:0] addr, wdata, rdata;
  int fail_count, checks_done, wake_cnt, busy_cnt, edges, w0, b0, dur0, dur1;
  assign sck_w = sck_oe ? sck_o : msck;
  assign do_w = do_oe ? do_o : src[3];
  spi_wake_port #(.DELAY_CYCLES(DLY)) u_dut (
    .ref_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .timer_clock_i(timer_clock), .first_timer_output_i(t0),
    .serial_data_input_i(di), .slave_select_n_i(ssn), .serial_clock_pin_i(sck_w),
    .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe), .port2_bit7_pin_o(do_o),
    .port2_bit7_pin_oe_o(do_oe), .port2_bit7_pin_i(do_w), .port3_bit1_input_i(src[0]),
    .port3_bit2_input_i(src[1]), .port3_bit3_input_i(src[2]), .port2_i(src[11:4]),
    .stop_mode_i(stop), .watchdog_reset_i(wdr), .receive_interrupt_line_o(irq),
    .stop_wake_o(wake), .recovery_delay_busy_o(busy));
  spi_ext_master u_m (.ref_clk_i(clk), .phase_i(ph), .dout_oe_i(do_oe), .dout_i(do_w),
    .sel_n_o(ssn),
    .sck_o(msck), .di_o(di));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    timer_clock <= ~timer_clock;
    // Timer-0 runs at half the timer clock so the source choice shows in the timing
    t0 <= t0 ^ timer_clock;
    sck_l <= sck_o;
    wake_cnt <= wake_cnt + int'(wake);
    busy_cnt <= busy_cnt + int'(busy);
    if (sck_oe && sck_o !== sck_l) edges <= edges + 1;
  end
  // ----
  // Bus and compare tasks
  // ----
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), exp, rdata & m);
    @(posedge clk);
  endtask : chk_reg
  // Source levels for recovery code k: only the selected source moves; codes 0 and 1 drive all sources low
  function automatic logic [11:0] src_low(input int k);
    if (k < 2) return 12'h000;
    if (k == 6) return 12'hf0f;
    if (k == 7) return 12'h00f;
    if (k == 8) return 12'hffe;
    return ~(12'h001 << (k - 2));
  endfunction : src_low
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_irq(output int n);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    if (irq !== 1'b1) begin
      fail_count++;
      $display("ERROR irq_wait expected 1 seen %b", irq);
      print_verdict();
    end
  endtask : wait_irq
  // ----
  // Scenarios
  // ----
  initial begin
    {nrst, wr, rd, timer_clock, t0, stop, wdr, ph, sck_l} = '0;
    src = '1;
    addr = 8'h00;
    wdata = 8'h00;
    {fail_count, checks_done, wake_cnt, busy_cnt, edges} = '0;
    pause(4);
    nrst <= 1'b1;
    pause(1);
    chk_reg(ADDR_CONTROL, 8'hff, CONTROL_RESET);
    chk_reg(ADDR_RECOVERY, 8'hff, 8'h00);
    chk_reg(8'h7f, 8'hff, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h01);
    wr_reg(ADDR_SHIFT, 8'h96);
    u_m.frame(1'b1);
    u_m.xfer(8'ha5, drove);
    u_m.frame(1'b0);
    chk("dout_driven", 8'h01, 8'(drove));
    chk("irq", 8'h01, 8'(irq));
    chk("dout_byte", 8'h96, u_m.rx_q);
    chk_reg(ADDR_CONTROL, 8'h12, 8'h10);
    chk_reg(ADDR_RECEIVE_BUFFER, 8'hff, 8'ha5);
    chk_reg(ADDR_CONTROL, 8'h10, 8'h00);
    // Falling-edge sampling with data-out released, two unread bytes
    ph <= 1'b1;
    wr_reg(ADDR_CONTROL, 8'h25);
    u_m.frame(1'b1);
    u_m.xfer(8'h3c, drove);
    u_m.xfer(8'hc3, drove);
    u_m.frame(1'b0);
    chk("dout_driven", 8'h00, 8'(drove));
    chk_reg(ADDR_CONTROL, 8'h12, 8'h12);
    chk_reg(ADDR_RECEIVE_BUFFER, 8'hff, 8'hc3);
    wr_reg(ADDR_CONTROL, 8'h27);
    chk_reg(ADDR_CONTROL, 8'h02, 8'h02);
    wr_reg(ADDR_CONTROL, 8'h25);
    chk_reg(ADDR_CONTROL, 8'h02, 8'h00);
    // Compare in stop: a mismatching frame, then a matching one
    ph <= 1'b0;
    wr_reg(ADDR_MATCH, 8'h5a);
    wr_reg(ADDR_CONTROL, 8'h09);
    stop <= 1'b1;
    w0 = wake_cnt;
    u_m.frame(1'b1);
    u_m.xfer(8'h55, drove);
    u_m.xfer(8'h5a, drove);
    u_m.frame(1'b0);
    chk("dout_driven", 8'h00, 8'(drove));
    chk("wake", 8'h00, 8'(wake_cnt - w0));
    chk_reg(ADDR_CONTROL, 8'h10, 8'h00);
    u_m.frame(1'b1);
    u_m.xfer(8'h5a, drove);
    chk("dout_driven", 8'h00, 8'(drove));
    u_m.xfer(8'h77, drove);
    u_m.frame(1'b0);
    chk("dout_driven", 8'h01, 8'(drove));
    chk("wake", 8'h01, 8'(wake_cnt - w0));
    chk_reg(ADDR_RECEIVE_BUFFER, 8'hff, 8'h77);
    chk("delay_ran", 8'h01, 8'(busy_cnt > 0));
    chk_reg(ADDR_RECOVERY, 8'h80, 8'h80);
    stop <= 1'b0;
    wdr <= 1'b1;
    pause(1);
    wdr <= 1'b0;
    chk_reg(ADDR_RECOVERY, 8'h80, 8'h00);
    // Every source code, low level except the NOR codes; last entry has the wrong level
    wr_reg(ADDR_CONTROL, 8'h00);
    b0 = busy_cnt;
    for (int k = 0; k < 9; k++) begin
      wr_reg(ADDR_RECOVERY, {1'b0, k >= 6, 1'b0, 3'(k < 8 ? k : 2), 2'b00});
      w0 = wake_cnt;
      stop <= 1'b1;
      pause(3);
      src <= src_low(k);
      pause(3);
      stop <= 1'b0;
      src <= '1;
      pause(3);
      chk("wake", 8'(k >= 2 && k < 8), 8'(wake_cnt - w0));
    end
    chk("delay_ran", 8'h00, 8'(busy_cnt - b0));
    chk_reg(ADDR_RECOVERY, 8'h7f, 8'h00);
    // Master transfers at the fastest and slowest divider
    for (int k = 0; k < 2; k++) begin
      u_m.set_di(k == 0);
      w0 = edges;
      wr_reg(ADDR_CONTROL, k ? 8'hc7 : 8'h81);
      wr_reg(ADDR_SHIFT, 8'hc3);
      wait_irq(b0);
      if (k) dur1 = b0;
      else dur0 = b0;
      pause(100);
      chk("sck_edges", 8'h10, 8'(edges - w0));
      chk_reg(ADDR_RECEIVE_BUFFER, 8'hff, k ? 8'h00 : 8'hff);
    end
    chk("div_ratio", 8'h01, 8'(dur1 > 12 * dur0 && dur1 < 20 * dur0));
    print_verdict();
  end
endmodule : spi_with_compare_wakeup_tb_top
